//--- rtl/nse_defines.vh
// Purpose: constants of the navigation status sentence encoder
// Assumes: 10 MHz i_mclk, byte addresses on the register bus
// Notes: definitions only, no logic
//
// Summary of operation
// - Hex-coded bytes go out as two characters, high nibble first, plus 30h.
// - Deviation sentence 21 carries course value, glideslope value, flag byte.
// - Course deviation is limited to -100..+100, left negative, right positive.
// - Glideslope value is eight-bit signed, two hex characters, after course.
// - Glideslope limited to -100..+100, up negative, down positive.
// - Flag byte bit order: back course, localizer, from, to, gs super/valid, nav.
// - To and from flags are never both set.
// - To and from cleared when over the station or with no signal.
// - Course sentence 22: validity character then three decimal degree digits.
// - Course and radial sentences repeat at 10 Hz from reset, unrequested.
// - Radial sentence 23: validity, three degree digits, one tenths digit.
// - Radial sentence keeps going while on a localizer, marked invalid.
// - Receiver status sentence goes on request and on every status change.
// - Status 28 frequencies: MHz minus 30h, then kHz/25 plus 30h.
// - Status 28 ends with 'N' normal or 'M' monitor.
// - Sentence 35: active then standby frequency, MHz codes 76h..88h or A2h.
// - Sentence 35 then transceiver state R/T/S/F and squelch '0' or '1'.
// - Sentence 36 carries four ASCII version characters.
// - Deviation sentence repeats at 10 Hz from reset.

`ifndef NSE_DEFINES_VH
`define NSE_DEFINES_VH

// ============================================================
// Register byte offsets
`define NSE_REG_CTRL 6'h00
`define NSE_REG_DEV 6'h04
`define NSE_REG_FLAGS 6'h08
`define NSE_REG_COURSE 6'h0c
`define NSE_REG_RADIAL 6'h10
`define NSE_REG_NAVF 6'h14
`define NSE_REG_COMF 6'h18
`define NSE_REG_COMST 6'h1c
`define NSE_REG_VER 6'h20
`define NSE_REG_STAT 6'h24

// ============================================================
// Field positions
`define NSE_CTRL_REQ_NAV 0
`define NSE_CTRL_REQ_COM 1
`define NSE_CTRL_REQ_VER 2
`define NSE_FLG_OVER 8
`define NSE_FLG_NOSIG 9
`define NSE_FLG_FROM 2
`define NSE_FLG_TO 3
`define NSE_FLG_LOC 1
`define NSE_CRS_VALID 15
`define NSE_RAD_VALID 31
`define NSE_NAVF_MON 31
`define NSE_COMST_SQ 2

// ============================================================
// Reset values
`define NSE_RST_ZERO 32'h00000000
`define NSE_RST_NAVF 32'h00446c00
`define NSE_RST_COMF 32'h00007600

// ============================================================
// Pending slots, in priority order (slot 0 wins)
`define NSE_S28 0
`define NSE_S35 1
`define NSE_S36 2
`define NSE_S21 3
`define NSE_S22 4
`define NSE_S23 5
`define NSE_NSLOT 6

// ============================================================
// Timing
`define NSE_CLK_HZ 10000000
`define NSE_PERIOD_MS 100

// ============================================================
// Characters
`define NSE_CH_DOLLAR 8'h24
`define NSE_CH_CLASS 8'h56
`define NSE_CH_VALID 8'h56
`define NSE_CH_ZERO 8'h30
`define NSE_CH_CR 8'h0d
`define NSE_CH_LF 8'h0a
`define NSE_CH_N 8'h4e
`define NSE_CH_M 8'h4d
`define NSE_HEX_OFS 4'h3

`endif

//--- rtl/nse_char_sel.v
// Purpose: character of the chosen sentence at a given position
// Assumes: i_sel one-hot, positions start at the dollar sign
// Notes: purely combinational, trailer is added by the caller
`timescale 1ns/1ns
`include "nse_defines.vh"

module nse_char_sel (
	input wire [5:0] i_sel,
	input wire [3:0] i_idx,
	input wire [31:0] i_prefix,
	input wire [7:0] i_cdev,
	input wire [7:0] i_gs,
	input wire [7:0] i_flags,
	input wire [8:0] i_course,
	input wire i_course_ok,
	input wire [8:0] i_radial,
	input wire [3:0] i_tenths,
	input wire i_radial_ok,
	input wire [31:0] i_navf,
	input wire [31:0] i_comf,
	input wire [2:0] i_comst,
	input wire [31:0] i_version,
	output reg [7:0] o_char,
	output reg o_last
);

	// ============================================================
	// Helpers
	function [7:0] hexc;
		input [3:0] n;
		begin
			hexc = {`NSE_HEX_OFS, n};
		end
	endfunction

	function [11:0] bcd3;
		input [8:0] v;
		reg [8:0] r;
		reg [8:0] h;
		reg [8:0] t;
		reg [8:0] o;
		begin
			h = v / 9'd100;
			r = v % 9'd100;
			t = r / 9'd10;
			o = r % 9'd10;
			bcd3 = {h[3:0], t[3:0], o[3:0]};
		end
	endfunction

	wire [11:0] crs_bcd = bcd3(i_course);
	wire [11:0] rad_bcd = bcd3(i_radial);
	reg [7:0] id_hi;
	reg [7:0] id_lo;
	reg [7:0] field;
	reg [3:0] last_idx;

	// Identifier, field character and length per sentence
	always @* begin
		id_hi = 8'h32;
		id_lo = 8'h31;
		field = `NSE_CH_ZERO;
		last_idx = 4'hd;
		case (1'b1)
		i_sel[`NSE_S21]: begin
			case (i_idx)
			4'h8: field = hexc(i_cdev[7:4]);
			4'h9: field = hexc(i_cdev[3:0]);
			4'ha: field = hexc(i_gs[7:4]);
			4'hb: field = hexc(i_gs[3:0]);
			4'hc: field = hexc(i_flags[7:4]);
			default: field = hexc(i_flags[3:0]);
			endcase
		end
		i_sel[`NSE_S22]: begin
			id_lo = 8'h32;
			last_idx = 4'hb;
			case (i_idx)
			4'h8: field = i_course_ok ? `NSE_CH_VALID : `NSE_CH_ZERO;
			4'h9: field = hexc(crs_bcd[11:8]);
			4'ha: field = hexc(crs_bcd[7:4]);
			default: field = hexc(crs_bcd[3:0]);
			endcase
		end
		i_sel[`NSE_S23]: begin
			id_lo = 8'h33;
			last_idx = 4'hc;
			case (i_idx)
			4'h8: field = i_radial_ok ? `NSE_CH_VALID : `NSE_CH_ZERO;
			4'h9: field = hexc(rad_bcd[11:8]);
			4'ha: field = hexc(rad_bcd[7:4]);
			4'hb: field = hexc(rad_bcd[3:0]);
			default: field = hexc(i_tenths);
			endcase
		end
		i_sel[`NSE_S28]: begin
			id_lo = 8'h38;
			last_idx = 4'hc;
			case (i_idx)
			4'h8: field = i_navf[7:0] - 8'h30;
			4'h9: field = {2'b00, i_navf[13:8]} + 8'h30;
			4'ha: field = i_navf[23:16] - 8'h30;
			4'hb: field = {2'b00, i_navf[29:24]} + 8'h30;
			default: field = i_navf[`NSE_NAVF_MON] ? `NSE_CH_M : `NSE_CH_N;
			endcase
		end
		i_sel[`NSE_S35]: begin
			id_hi = 8'h33;
			id_lo = 8'h35;
			case (i_idx)
			4'h8: field = i_comf[7:0] - 8'h30;
			4'h9: field = {2'b00, i_comf[13:8]} + 8'h30;
			4'ha: field = i_comf[23:16] - 8'h30;
			4'hb: field = {2'b00, i_comf[29:24]} + 8'h30;
			4'hc: begin
				case (i_comst[1:0])
				2'h0: field = 8'h52;
				2'h1: field = 8'h54;
				2'h2: field = 8'h53;
				default: field = 8'h46;
				endcase
			end
			default: field = i_comst[`NSE_COMST_SQ] ? 8'h31 : 8'h30;
			endcase
		end
		default: begin
			id_hi = 8'h33;
			id_lo = 8'h36;
			last_idx = 4'hb;
			case (i_idx)
			4'h8: field = i_version[31:24];
			4'h9: field = i_version[23:16];
			4'ha: field = i_version[15:8];
			default: field = i_version[7:0];
			endcase
		end
		endcase
	end

	// Frame head common to all sentences
	always @* begin
		o_last = (i_idx == last_idx);
		case (i_idx)
		4'h0: o_char = `NSE_CH_DOLLAR;
		4'h1: o_char = i_prefix[31:24];
		4'h2: o_char = i_prefix[23:16];
		4'h3: o_char = i_prefix[15:8];
		4'h4: o_char = i_prefix[7:0];
		4'h5: o_char = `NSE_CH_CLASS;
		4'h6: o_char = id_hi;
		4'h7: o_char = id_lo;
		default: o_char = field;
		endcase
	end

endmodule

//--- rtl/nse_encoder.v
// Purpose: sentence encoder top, register slave and byte stream source
// Assumes: UART outside takes bytes on valid and ready
// Notes: fields are read live while a sentence is sent
`timescale 1ns/1ns
`include "nse_defines.vh"

module nse_encoder #(
	// Arbitrary maker prefix, four ASCII characters
	parameter [31:0] P_PREFIX = 32'h50585a59,
	parameter [23:0] P_TICK_CYCLES =
		`NSE_CLK_HZ / 1000 * `NSE_PERIOD_MS
) (
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_ce,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	output reg [7:0] o_tx_data,
	output reg o_tx_valid,
	input wire i_tx_ready
);

	// ============================================================
	// States
	// IDLE picks a slot, BODY walks head and fields,
	// TAIL sends the checksum and the line end
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_BODY = 3'b010;
	localparam [2:0] ST_TAIL = 3'b100;

	// ============================================================
	// Registers
	// Host-written fields, read live by the sender, so a write
	// during a sentence may show in its later characters
	reg [15:0] dev;
	reg [9:0] flags_raw;
	reg [15:0] course;
	reg [31:0] radial;
	reg [31:0] navf;
	reg [31:0] comf;
	reg [2:0] comst;
	reg [31:0] version;
	reg [5:0] pending;
	reg [23:0] tick_cnt;
	reg [2:0] state;
	reg [3:0] idx;
	reg [1:0] tidx;
	reg [5:0] sel;
	reg [7:0] cksum;

	wire [7:0] cur_char;
	wire cur_last;

	// ============================================================
	// Field conditioning
	// Signed clamp to -100..+100; the raw word still reads back
	// unchanged, so software sees what it wrote
	function [7:0] clamp100;
		input [7:0] v;
		begin
			if (!v[7] && v > 8'h64)
				clamp100 = 8'h64;
			else if (v[7] && v < 8'h9c)
				clamp100 = 8'h9c;
			else
				clamp100 = v;
		end
	endfunction

	// Byte-lane merge of a write into the old word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		reg [31:0] m;
		begin
			m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			merge = (old & ~m) | (wd & m);
		end
	endfunction

	wire [7:0] cdev_lim = clamp100(dev[7:0]);
	wire [7:0] gs_lim = clamp100(dev[15:8]);

	// Direction flags dropped over the station or without signal
	// Both set at once is treated as neither, never passed on
	wire dir_kill = flags_raw[`NSE_FLG_OVER] | flags_raw[`NSE_FLG_NOSIG] |
		(flags_raw[`NSE_FLG_TO] & flags_raw[`NSE_FLG_FROM]);
	wire [7:0] flags_out = {flags_raw[7:4],
		flags_raw[`NSE_FLG_TO] & ~dir_kill,
		flags_raw[`NSE_FLG_FROM] & ~dir_kill,
		flags_raw[1:0]};

	// Out-of-range degrees are reported invalid rather than wrapped
	// A localizer in use always marks the radial invalid
	wire course_ok = course[`NSE_CRS_VALID] & (course[8:0] < 9'd360);
	wire radial_ok = radial[`NSE_RAD_VALID] & (radial[8:0] < 9'd360) &
		(radial[19:16] < 4'ha) &
		~flags_raw[`NSE_FLG_LOC];

	// ============================================================
	// Character source
	// Values are conditioned here, the layout lives in the selector
	nse_char_sel u_char (
		.i_sel(sel),
		.i_idx(idx),
		.i_prefix(P_PREFIX),
		.i_cdev(cdev_lim),
		.i_gs(gs_lim),
		.i_flags(flags_out),
		.i_course(course[8:0]),
		.i_course_ok(course_ok),
		.i_radial(radial[8:0]),
		.i_tenths(radial[19:16]),
		.i_radial_ok(radial_ok),
		.i_navf(navf),
		.i_comf(comf),
		.i_comst(comst),
		.i_version(version),
		.o_char(cur_char),
		.o_last(cur_last)
	);

	// ============================================================
	// Bus decode
	// Every access takes two cycles: a wait cycle, then the accept
	// edge; costs throughput but keeps readdata registered
	wire bus_req = i_avs_read | i_avs_write;
	wire bus_take = bus_req & ~o_avs_waitrequest;
	wire wr_take = bus_take & i_avs_write;
	wire [31:0] wd = i_avs_writedata;
	wire [3:0] be = i_avs_byteenable;
	wire wr_ctrl = wr_take & (i_avs_address == `NSE_REG_CTRL);
	wire wr_navf = wr_take & (i_avs_address == `NSE_REG_NAVF);
	wire [31:0] navf_new = merge(navf, wd, be);

	// Merged write words, cut back to each register's width
	// on purpose; the upper lanes have no storage behind them
	wire [31:0] dev_wide = merge({16'h0000, dev}, wd, be);
	wire [31:0] flags_wide = merge({22'h000000, flags_raw}, wd, be);
	wire [31:0] course_wide = merge({16'h0000, course}, wd, be);
	wire [15:0] next_dev = dev_wide[15:0];
	wire [9:0] next_flags = flags_wide[9:0];
	wire [15:0] next_course = course_wide[15:0];

	reg [31:0] next_rdata;

	// Read multiplexer, unmapped words read zero
	// Sampled in the wait cycle, so readdata comes from a flop
	always @* begin
		case (i_avs_address)
		`NSE_REG_DEV: next_rdata = {16'h0000, dev};
		`NSE_REG_FLAGS: next_rdata = {22'h000000, flags_raw};
		`NSE_REG_COURSE: next_rdata = {16'h0000, course};
		`NSE_REG_RADIAL: next_rdata = radial;
		`NSE_REG_NAVF: next_rdata = navf;
		`NSE_REG_COMF: next_rdata = comf;
		`NSE_REG_COMST: next_rdata = {29'h00000000, comst};
		`NSE_REG_VER: next_rdata = version;
		`NSE_REG_STAT:
			next_rdata = {23'h000000, state != ST_IDLE, 2'b00, pending};
		default: next_rdata = `NSE_RST_ZERO;
		endcase
	end

	// One wait cycle per access, then a one-cycle accept
	// A request dropped early just lets waitrequest return high
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= `NSE_RST_ZERO;
		end else if (i_ce) begin
			if (bus_req && o_avs_waitrequest) begin
				o_avs_waitrequest <= 1'b0;
				o_avs_readdata <= next_rdata;
			end else begin
				o_avs_waitrequest <= 1'b1;
			end
		end
	end

	// Writable registers
	// CTRL is write-only, its bits only raise pending slots
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			dev <= 16'h0000;
			flags_raw <= 10'h000;
			course <= 16'h0000;
			radial <= `NSE_RST_ZERO;
			navf <= `NSE_RST_NAVF;
			comf <= `NSE_RST_COMF;
			comst <= 3'b000;
			version <= 32'h30303030;
		end else if (i_ce && wr_take) begin
			case (i_avs_address)
			`NSE_REG_DEV: dev <= next_dev;
			`NSE_REG_FLAGS: flags_raw <= next_flags;
			`NSE_REG_COURSE: course <= next_course;
			`NSE_REG_RADIAL: radial <= merge(radial, wd, be);
			`NSE_REG_NAVF: navf <= navf_new;
			`NSE_REG_COMF: comf <= merge(comf, wd, be);
			`NSE_REG_COMST: comst <= wd[2:0];
			`NSE_REG_VER: version <= merge(version, wd, be);
			// Unmapped offsets change nothing
			default: comst <= comst;
			endcase
		end
	end

	// ============================================================
	// Periodic tick
	wire tick = (tick_cnt == P_TICK_CYCLES - 24'h000001);

	// 10 Hz timer, free running from reset
	// Never held back by a backlog, so the period stays exact
	always @(posedge i_mclk) begin
		if (!i_rst_n)
			tick_cnt <= 24'h000000;
		else if (i_ce)
			tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
	end

	// ============================================================
	// Pending sentences
	wire [5:0] set_req;
	wire [5:0] grant;
	wire [5:0] clr_req;
	wire nav_changed = wr_navf & (navf_new != navf);

	assign set_req[`NSE_S28] = (wr_ctrl & wd[`NSE_CTRL_REQ_NAV]) |
		nav_changed;
	assign set_req[`NSE_S35] = wr_ctrl & wd[`NSE_CTRL_REQ_COM];
	assign set_req[`NSE_S36] = wr_ctrl & wd[`NSE_CTRL_REQ_VER];
	// A tick on a slot still pending merges into one sentence
	assign set_req[`NSE_S21] = tick;
	assign set_req[`NSE_S22] = tick;
	assign set_req[`NSE_S23] = tick;

	// Fixed priority pick, lowest slot first
	assign grant = pending & (~pending + 6'h01);
	// Waiting for the last line feed to drain leaves two idle
	// cycles between sentences, so the host sees every new start
	wire start = (state == ST_IDLE) & ~o_tx_valid &
		(pending != 6'h00);
	assign clr_req = start ? grant : 6'h00;

	genvar g;
	generate
		for (g = 0; g < `NSE_NSLOT; g = g + 1) begin : g_pend
			// A new request in the grant cycle stays pending
			always @(posedge i_mclk) begin
				if (!i_rst_n)
					pending[g] <= 1'b0;
				else if (i_ce) begin
					if (set_req[g])
						pending[g] <= 1'b1;
					else if (clr_req[g])
						pending[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ============================================================
	// Sender
	// A character may be replaced in the cycle it is taken, so the
	// stream runs one character per cycle while the sink keeps up
	wire slot_free = ~o_tx_valid | i_tx_ready;
	reg [7:0] tail_char;

	// Checksum then line end
	// Checksum covers every character after the dollar sign
	always @* begin
		case (tidx)
		2'h0: tail_char = {`NSE_HEX_OFS, cksum[7:4]};
		2'h1: tail_char = {`NSE_HEX_OFS, cksum[3:0]};
		2'h2: tail_char = `NSE_CH_CR;
		default: tail_char = `NSE_CH_LF;
		endcase
	end

	// One sentence at a time, never interleaved
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			idx <= 4'h0;
			tidx <= 2'h0;
			sel <= 6'h00;
			cksum <= 8'h00;
			o_tx_data <= 8'h00;
			o_tx_valid <= 1'b0;
		end else if (i_ce) begin
			case (state)
			ST_IDLE: begin
				// Drain the line feed, then pick the next slot
				if (o_tx_valid && i_tx_ready)
					o_tx_valid <= 1'b0;
				if (start) begin
					sel <= grant;
					idx <= 4'h0;
					cksum <= 8'h00;
					state <= ST_BODY;
				end
			end
			ST_BODY: begin
				// Head and fields, one character per free slot
				if (slot_free) begin
					o_tx_data <= cur_char;
					o_tx_valid <= 1'b1;
					if (idx != 4'h0)
						cksum <= cksum ^ cur_char;
					if (cur_last) begin
						tidx <= 2'h0;
						state <= ST_TAIL;
					end else begin
						idx <= idx + 4'h1;
					end
				end
			end
			ST_TAIL: begin
				// Checksum pair, CR, then LF
				if (slot_free) begin
					o_tx_data <= tail_char;
					o_tx_valid <= 1'b1;
					tidx <= tidx + 2'h1;
					if (tidx == 2'h3)
						state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

//--- tb/nse_encoder_chk.sv
// Purpose: port checks of the sentence encoder
// Assumes: one wait state on the bus, clock enable high
// Notes: bound to nse_encoder at the foot of this file
`timescale 1ns/1ns
module nse_encoder_chk #(
	parameter [31:0] P_PREFIX = 32'h50585a59,
	parameter [23:0] P_TICK_CYCLES = 24'h000190
) (
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_ce,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire [7:0] o_tx_data,
	input wire o_tx_valid,
	input wire i_tx_ready
);
	// ============================================================
	// Bus handshake
	// Frozen cycles are skipped, the enable stops everything
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n || !i_ce);
	a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_answer: assert property ((i_avs_read || i_avs_write) &&
		o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_idle_wait: assert property (!(i_avs_read || i_avs_write)
		|=> o_avs_waitrequest)
		else $error("waitrequest dropped without request");
	a_reset_state: assert property (disable iff (1'h0)
		!i_rst_n && i_ce |=> o_avs_waitrequest && !o_tx_valid &&
		o_avs_readdata == 32'h00000000)
		else $error("outputs not cleared by reset");
	// ============================================================
	// Character stream
	a_tx_hold: assert property (o_tx_valid && !i_tx_ready
		|=> o_tx_valid && $stable(o_tx_data))
		else $error("character changed while stalled");
	a_frame_start: assert property ($rose(o_tx_valid) |->
		o_tx_data == 8'h24)
		else $error("sentence does not open with dollar");
	a_prefix_first: assert property (o_tx_valid && i_tx_ready &&
		o_tx_data == 8'h24 |=> o_tx_data == P_PREFIX[31:24])
		else $error("prefix does not follow dollar");
	a_byte_next: assert property (o_tx_valid && i_tx_ready &&
		o_tx_data != 8'h0a |=> o_tx_valid)
		else $error("gap inside a sentence");
	a_lf_gap: assert property (o_tx_valid && i_tx_ready &&
		o_tx_data == 8'h0a |=> !o_tx_valid ##1 !o_tx_valid)
		else $error("sentences closer than two idle cycles");
endmodule
bind nse_encoder nse_encoder_chk #(.P_PREFIX(P_PREFIX),
	.P_TICK_CYCLES(P_TICK_CYCLES)) u_chk (.i_mclk(i_mclk),
	.i_rst_n(i_rst_n), .i_ce(i_ce), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_tx_data(o_tx_data),
	.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready));

//--- tb/nse_host_model.sv
// Purpose: host taking sentences off the character stream
// Assumes: ids below 64, sentences shorter than 32 characters
// Notes: keeps the last sentence of each id and when it ended
`timescale 1ns/1ns
module nse_host_model (
	input wire i_mclk,
	input wire i_rst_n,
	input wire [7:0] i_data,
	input wire i_valid,
	input wire i_slow,
	output logic o_ready
);
	logic [7:0] line [0:31];
	logic [7:0] last [0:63][0:31];
	int pos = 0;
	int cyc = 0;
	int total = 0;
	int id;
	int cnt [0:63];
	int len [0:63];
	int seqn [0:63];
	int t_end [0:63];
	int t_prev [0:63];
	// ============================================================
	// Capture, non-blocking so the bench reads settled values
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		// Slow host: every other cycle; always ready in reset
		o_ready <= !i_rst_n || !i_slow || !o_ready;
		if (!i_rst_n) begin
			pos <= 0;
		end else if (i_valid && o_ready) begin
			line[pos] <= i_data;
			pos <= (pos < 31) ? pos + 1 : pos;
			if (i_data == 8'h0a) begin
				id = (line[6] - 8'h30) * 10 + (line[7] - 8'h30);
				id = id & 63;
				for (int k = 0; k < 31; k++) begin
					last[id][k] <= (k == pos) ? i_data : line[k];
				end
				len[id] <= pos + 1;
				cnt[id] <= cnt[id] + 1;
				seqn[id] <= total;
				total <= total + 1;
				t_prev[id] <= t_end[id];
				t_end[id] <= cyc;
				pos <= 0;
			end
		end
	end
endmodule

//--- tb/nse_encoder_test.sv
// Purpose: self-checking bench of the sentence encoder
// Assumes: short tick period, host model on the stream
// Notes: register writes through the Avalon tasks only
`timescale 1ns/1ns
module nse_encoder_test;
	localparam [23:0] TICK = 24'h000190;
	localparam [31:0] PFX = 32'h50585a59; // Arbitrary prefix
	localparam [31:0] STC = 32'h52545346; // State letters R T S F
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [5:0] adr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wreq;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	int bad_count = 0;
	int n_compared = 0;
	always #50 i_mclk = ~i_mclk;
	nse_encoder #(.P_PREFIX(PFX), .P_TICK_CYCLES(TICK)) dut (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.o_tx_data(tx_data), .o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready));
	nse_host_model host (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_data(tx_data), .i_valid(tx_valid), .i_slow(slow),
		.o_ready(tx_ready));
	// ============================================================
	// Common tasks
	task automatic final_report;
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic lost;
		bad_count++;
		$display("ERROR %0t: wait ran out", $time);
		final_report();
	endtask
	// Holds the request until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int i;
		@(posedge i_mclk);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		for (i = 0; i < 20; i++) begin
			@(posedge i_mclk);
			if (wreq === 1'b0) break;
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) lost();
	endtask
	task automatic wait_new(input int id, input int n);
		int c;
		int i;
		c = host.cnt[id];
		for (i = 0; i < 4 * TICK * n; i++) begin
			@(posedge i_mclk);
			if (host.cnt[id] >= c + n) break;
		end
		if (i == 4 * TICK * n) lost();
	endtask
	function automatic [15:0] hx(input [7:0] v);
		hx = {4'h3, v[7:4], 4'h3, v[3:0]};
	endfunction
	// Rebuilds the whole sentence, checksum included
	task automatic check_sent(input int id, input logic [63:0] f,
		input int n);
		logic [7:0] e [$];
		logic [7:0] x;
		e = {8'h24, PFX[31:24], PFX[23:16], PFX[15:8], PFX[7:0], 8'h56};
		e.push_back(8'h30 + 8'(id / 10));
		e.push_back(8'h30 + 8'(id % 10));
		for (int k = n - 1; k >= 0; k--) e.push_back(f[8 * k +: 8]);
		x = 8'h00;
		for (int k = 1; k < e.size(); k++) x ^= e[k];
		e.push_back(hx(x) >> 8);
		e.push_back(hx(x) & 16'h00ff);
		e.push_back(8'h0d);
		e.push_back(8'h0a);
		check(host.len[id], e.size());
		for (int k = 0; k < e.size(); k++)
			check(host.last[id][k], e[k]);
	endtask
	// ============================================================
	// Scenarios
	task automatic t_period;
		bus(1'b0, 6'h14, 32'h0);
		check(q, 32'h00446c00);
		bus(1'b0, 6'h3c, 32'h0);
		check(q, 32'h0);
		wait_new(23, 2);
		check(host.t_end[21] - host.t_prev[21], TICK);
		check(host.t_end[22] - host.t_prev[22], TICK);
		check(host.t_end[23] - host.t_prev[23], TICK);
	endtask
	task automatic dev_case(input [31:0] dv, input [31:0] fl,
		input [23:0] ex);
		bus(1'b1, 6'h04, dv);
		bus(1'b1, 6'h08, fl);
		wait_new(21, 2);
		check_sent(21, {hx(ex[23:16]), hx(ex[15:8]), hx(ex[7:0])}, 6);
	endtask
	task automatic t_dev;
		dev_case(32'h7888, 32'h0fc, 24'h9c64f0);
		dev_case(32'h9b64, 32'h1fb, 24'h649cf3);
		dev_case(32'h00f6, 32'h2f7, 24'hf600f3);
	endtask
	task automatic crs_case(input [31:0] v, input [31:0] ex);
		bus(1'b1, 6'h0c, v);
		wait_new(22, 2);
		check_sent(22, ex, 4);
	endtask
	task automatic t_course;
		crs_case(32'h8167, 32'h56333539);
		crs_case(32'h0167, 32'h30333539);
		crs_case(32'h8168, 32'h30333630);
	endtask
	task automatic t_radial;
		bus(1'b1, 6'h08, 32'h002);
		bus(1'b1, 6'h10, 32'h800400a5);
		wait_new(23, 2);
		check_sent(23, 40'h3031363534, 5);
		bus(1'b1, 6'h08, 32'h000);
		wait_new(23, 2);
		check_sent(23, 40'h5631363534, 5);
	endtask
	task automatic t_nav;
		bus(1'b1, 6'h14, 32'ha06f0475);
		wait_new(28, 1);
		check_sent(28, 40'h45343f504d, 5);
		bus(1'b1, 6'h00, 32'h1);
		wait_new(28, 1);
		check_sent(28, 40'h45343f504d, 5);
		bus(1'b1, 6'h14, 32'h206f0475);
		wait_new(28, 1);
		check_sent(28, 40'h45343f504e, 5);
	endtask
	task automatic t_com;
		bus(1'b1, 6'h18, 32'h167c0477);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 6'h1c, 32'(s | ((s & 1) << 2)));
			bus(1'b1, 6'h00, 32'h2);
			wait_new(35, 1);
			check_sent(35, {32'h47344c46, STC[31 - 8 * s -: 8],
				8'h30 + 8'(s & 1)}, 6);
		end
	endtask
	task automatic t_prio;
		bus(1'b1, 6'h20, 32'h31303345);
		slow <= 1'b1;
		bus(1'b1, 6'h00, 32'h7);
		wait_new(36, 1);
		check_sent(36, 32'h31303345, 4);
		check(host.seqn[35] - host.seqn[28], 1);
		check(host.seqn[36] - host.seqn[35], 1);
		slow <= 1'b0;
	endtask
	// Enable low from an idle gap: no tick, no character at all
	task automatic t_freeze;
		int n;
		wait_new(23, 1);
		ce <= 1'b0;
		n = host.total;
		repeat (2 * TICK) @(posedge i_mclk);
		check(host.total, n);
		check(tx_valid, 1'b0);
		ce <= 1'b1;
		wait_new(21, 1);
	endtask
	// ============================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_period();
		t_dev();
		t_course();
		t_radial();
		t_nav();
		t_com();
		t_prio();
		t_freeze();
		final_report();
	end
endmodule
